// ---- design/sam_map.svh ----
// register offsets, field positions, reset values and timing figures of the alarm manager
`ifndef SAM_MAP_SVH
`define SAM_MAP_SVH
`define SAM_REG_CTRL   5'h00
`define SAM_REG_THR    5'h04
`define SAM_REG_STAT   5'h08
`define SAM_REG_IRQ    5'h0c
`define SAM_REG_MASK   5'h10
`define SAM_CTRL_TQSEL 0
`define SAM_CTRL_NETEN 1
`define SAM_NETEN_RST  1'b1
`define SAM_TQSEL_RST  1'b0
`define SAM_THR_RST    16'h012c
`define SAM_THR_MIN    16'h0001
`define SAM_THR_MAX    16'h7530
`define SAM_IRQ_RAISE  0
`define SAM_IRQ_CLEAR  1
`define SAM_ST_ACT     8
`define SAM_ST_ENER    9
`define SAM_ST_STEADY  10
`define SAM_ST_BLK     12
`define SAM_RESP_OK    2'b00
`define SAM_RESP_ERR   2'b10
`define SAM_C_CPU      8'hf0
`define SAM_C_NETMOD   8'h82
`define SAM_C_WRAP     8'h72
`define SAM_C_GEAR     8'h71
`define SAM_C_TQ       8'h68
`define SAM_C_NET      8'h81
`define SAM_C_OPDATA   8'h70
`define SAM_C_MECH     8'h6d
`define SAM_C_HOMEOFS  8'h6a
`define SAM_C_DEV      8'h10
`define SAM_C_OVL      8'h30
`define SAM_BLK_ONE    4'h1
`define SAM_BLK_SEVEN  4'h7
`define SAM_LD_100     9'h064
`define SAM_LD_125     9'h07d
`define SAM_LD_150     9'h096
`define SAM_LD_250     9'h0fa
`define SAM_LD_300     9'h12c
`define SAM_LD_375     9'h177
`define SAM_OVL_125_MS 14'h2710
`define SAM_OVL_150_MS 14'h0fa0
`define SAM_OVL_250_MS 14'h03e8
`define SAM_OVL_300_MS 14'h01f4
`define SAM_OVL_375_MS 14'h012c
`define SAM_TICK_NS    1000000
`define SAM_CLK_NS     25
`define SAM_SLOTS      11
`endif

// ---- design/sam_pkg.sv ----
// types and per-alarm lookup tables of the alarm manager
`include "sam_map.svh"
package sam_pkg;
    typedef enum logic [1:0] {SAM_OK = 2'b01, SAM_ALM = 2'b10} sam_mode_t;

    // slot order is detection priority; slots 0..3 clear only by power cycle
    typedef enum logic [3:0] {
        SL_CPU = 4'h0, SL_NETMOD = 4'h1, SL_WRAP = 4'h2, SL_GEAR = 4'h3,
        SL_TQ = 4'h4, SL_NET = 4'h5, SL_OPDATA = 4'h6, SL_MECH = 4'h7,
        SL_HOMEOFS = 4'h8, SL_DEV = 4'h9, SL_OVL = 4'ha
    } sam_slot_t;

    typedef struct packed {
        sam_mode_t   mode;
        sam_slot_t   slot;
        logic [4:0]  s1;
        logic [4:0]  s2;
        logic        started;
        logic        tqSel;
        logic        netEn;
        logic [15:0] thr;
        logic [1:0]  irqSt;
        logic [1:0]  irqMask;
        logic [15:0] div;
        logic [13:0] ovl;
        logic        awGot;
        logic [4:0]  awAddr;
        logic        wGot;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        awRdy;
        logic        wRdy;
        logic        bValid;
        logic [1:0]  bResp;
        logic        arRdy;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic        faultFree;
        logic        moveOut;
        logic        readyOut;
        logic        stopOut;
        logic        motorEn;
        logic        ledSteady;
        logic [3:0]  ledBlk;
        logic [7:0]  code;
        logic        irq;
    } sam_state_t;

    function automatic logic [7:0] sam_code(input sam_slot_t s);
        unique case (s)
            SL_CPU:     sam_code = `SAM_C_CPU;
            SL_NETMOD:  sam_code = `SAM_C_NETMOD;
            SL_WRAP:    sam_code = `SAM_C_WRAP;
            SL_GEAR:    sam_code = `SAM_C_GEAR;
            SL_TQ:      sam_code = `SAM_C_TQ;
            SL_NET:     sam_code = `SAM_C_NET;
            SL_OPDATA:  sam_code = `SAM_C_OPDATA;
            SL_MECH:    sam_code = `SAM_C_MECH;
            SL_HOMEOFS: sam_code = `SAM_C_HOMEOFS;
            SL_DEV:     sam_code = `SAM_C_DEV;
            default:    sam_code = `SAM_C_OVL;
        endcase
    endfunction : sam_code

    function automatic logic sam_pwr_only(input sam_slot_t s);
        sam_pwr_only = (s <= SL_GEAR);
    endfunction : sam_pwr_only

    // motor stays energised for every slot but these
    function automatic logic sam_energ(input sam_slot_t s);
        sam_energ = !(s <= SL_TQ);
    endfunction : sam_energ

    function automatic logic [13:0] sam_ovl_limit(input logic [8:0] ld);
        if (ld >= `SAM_LD_375)      sam_ovl_limit = `SAM_OVL_375_MS;
        else if (ld >= `SAM_LD_300) sam_ovl_limit = `SAM_OVL_300_MS;
        else if (ld >= `SAM_LD_250) sam_ovl_limit = `SAM_OVL_250_MS;
        else if (ld >= `SAM_LD_150) sam_ovl_limit = `SAM_OVL_150_MS;
        else if (ld >= `SAM_LD_125) sam_ovl_limit = `SAM_OVL_125_MS;
        else                        sam_ovl_limit = '0;
    endfunction : sam_ovl_limit
endpackage : sam_pkg

// ---- design/sam_alarm_manager.sv ----
// alarm detection, latching and clearing with an AXI4-Lite register file
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "sam_map.svh"

module sam_alarm_manager
    import sam_pkg::*;
#(
    parameter int MS_CYCLES = `SAM_TICK_NS / `SAM_CLK_NS
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        torque_off_in_a,
    input  wire logic        torque_off_in_b,
    input  wire logic        forward_limit_in,
    input  wire logic        reverse_limit_in,
    input  wire logic        fault_clear_in,
    input  wire logic        homeOffsetMove,
    input  wire logic        homeSet,
    input  wire logic        atMechLimit,
    input  wire logic        sdStart,
    input  wire logic        sdSpeedZero,
    input  wire logic        wrapCmd,
    input  wire logic        wrapEnabled,
    input  wire logic        speedOverLimit,
    input  wire logic        gearRangeBad,
    input  wire logic        wrapRangeBad,
    input  wire logic        netLost,
    input  wire logic        operating,
    input  wire logic        netModuleErr,
    input  wire logic        cpuFault,
    input  wire logic [15:0] posDeviation,
    input  wire logic [8:0]  loadPct,
    input  wire logic        motionReq,
    output logic             fault_free_out,
    output logic             moveOut,
    output logic             readyOut,
    output logic             stopOut,
    output logic             motorEnOut,
    output logic             ledSteady,
    output logic [3:0]       ledBlinks,
    output logic [7:0]       alarmCode,
    output logic             irq,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [4:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);
    localparam sam_state_t RST_VAL = '{
        mode: SAM_OK, slot: SL_CPU, thr: `SAM_THR_RST,
        tqSel: `SAM_TQSEL_RST, netEn: `SAM_NETEN_RST,
        awRdy: 1'b1, wRdy: 1'b1, arRdy: 1'b1,
        faultFree: 1'b1, readyOut: 1'b1, motorEn: 1'b1,
        default: '0
    };

    sam_state_t                 s_r;
    sam_state_t                 s_nxt;
    logic [`SAM_SLOTS-1:0]      det;
    logic                       anyDet;
    sam_slot_t                  newSlot;
    logic [13:0]                ovlLim;
    logic                       tick;
    logic                       act;
    logic                       clrReq;
    logic                       clrOk;

    // synchronised pins: s2 bits are torque a, torque b, fwd, rev, clear
    assign act    = (s_r.mode == SAM_ALM);
    assign clrReq = s_r.s2[4];
    assign ovlLim = sam_ovl_limit(loadPct);
    assign tick   = (s_r.div == 16'(MS_CYCLES - 1));

    always_comb begin
        det             = '0;
        det[SL_CPU]     = cpuFault;
        det[SL_NETMOD]  = netModuleErr;
        det[SL_WRAP]    = !s_r.started && wrapRangeBad;
        det[SL_GEAR]    = gearRangeBad;
        det[SL_TQ]      = s_r.tqSel && !(s_r.s2[0] && s_r.s2[1]);
        det[SL_NET]     = s_r.netEn && netLost && operating;
        det[SL_OPDATA]  = (sdStart && sdSpeedZero) || (wrapCmd && !wrapEnabled)
                          || speedOverLimit;
        det[SL_MECH]    = homeSet && atMechLimit;
        det[SL_HOMEOFS] = homeOffsetMove && (s_r.s2[2] || s_r.s2[3]);
        det[SL_DEV]     = posDeviation > s_r.thr;
        det[SL_OVL]     = (ovlLim != '0) && (s_r.ovl >= ovlLim);
    end

    // lowest slot wins when several causes appear together
    always_comb begin
        newSlot = SL_OVL;
        for (int i = `SAM_SLOTS - 1; i >= 0; i--) begin
            if (det[i]) begin
                newSlot = sam_slot_t'(4'(i));
            end
        end
    end
    assign anyDet = |det;
    // a cleared cause is checked against the latched slot only
    assign clrOk  = act && clrReq && !sam_pwr_only(s_r.slot) && !det[s_r.slot];

    function automatic logic [31:0] rd_word(input sam_state_t s, input logic [4:0] a);
        rd_word = '0;
        unique case (a)
            `SAM_REG_CTRL: begin
                rd_word[`SAM_CTRL_TQSEL] = s.tqSel;
                rd_word[`SAM_CTRL_NETEN] = s.netEn;
            end
            `SAM_REG_THR: rd_word[15:0] = s.thr;
            `SAM_REG_STAT: begin
                rd_word[7:0]                    = s.code;
                rd_word[`SAM_ST_ACT]            = (s.mode == SAM_ALM);
                rd_word[`SAM_ST_ENER]           = s.motorEn;
                rd_word[`SAM_ST_STEADY]         = s.ledSteady;
                rd_word[`SAM_ST_BLK +: 4]       = s.ledBlk;
            end
            `SAM_REG_IRQ:  rd_word[1:0] = s.irqSt;
            `SAM_REG_MASK: rd_word[1:0] = s.irqMask;
            default: rd_word = '0;
        endcase
    endfunction : rd_word

    function automatic logic mapped(input logic [4:0] a);
        mapped = (a == `SAM_REG_CTRL) || (a == `SAM_REG_THR) || (a == `SAM_REG_STAT)
                 || (a == `SAM_REG_IRQ) || (a == `SAM_REG_MASK);
    endfunction : mapped

    always_comb begin
        logic [1:0]  irqSet;
        logic [1:0]  irqW1c;
        logic [15:0] thrNew;
        logic        nAct;
        irqSet = '0;
        irqW1c = '0;
        thrNew = s_r.thr;
        nAct   = 1'b0;
        s_nxt  = s_r;
        s_nxt.s1 = {fault_clear_in, reverse_limit_in, forward_limit_in,
                    torque_off_in_b, torque_off_in_a};
        s_nxt.s2 = s_r.s1;
        s_nxt.started = 1'b1;
        // ms tick from the clock; overload time accumulates per tick
        s_nxt.div = tick ? '0 : s_r.div + 16'h0001;
        if (ovlLim == '0) begin
            s_nxt.ovl = '0;
        end else if (tick && s_r.ovl < ovlLim) begin
            s_nxt.ovl = s_r.ovl + 14'h0001;
        end

        unique case (s_r.mode)
            SAM_OK: begin
                if (anyDet) begin
                    s_nxt.mode = SAM_ALM;
                    s_nxt.slot = newSlot;
                    irqSet[`SAM_IRQ_RAISE] = 1'b1;
                end
            end
            SAM_ALM: begin
                // a power-cycle alarm takes over a clearable one; a processor fault takes over any other alarm
                if (anyDet && ((sam_pwr_only(newSlot) && !sam_pwr_only(s_r.slot))
                               || (newSlot == SL_CPU && s_r.slot != SL_CPU))) begin
                    s_nxt.slot = newSlot;
                    irqSet[`SAM_IRQ_RAISE] = 1'b1;
                end else if (clrOk) begin
                    s_nxt.mode = SAM_OK;
                    irqSet[`SAM_IRQ_CLEAR] = 1'b1;
                end
            end
        endcase

        nAct              = (s_nxt.mode == SAM_ALM);
        s_nxt.faultFree   = !nAct;
        s_nxt.moveOut     = motionReq && !nAct;
        s_nxt.stopOut     = nAct;
        s_nxt.readyOut    = !nAct;
        s_nxt.motorEn     = !nAct || sam_energ(s_nxt.slot);
        s_nxt.ledSteady   = nAct && (s_nxt.slot == SL_CPU);
        s_nxt.ledBlk      = !nAct ? 4'h0 :
                            (s_nxt.slot == SL_CPU) ? 4'h0 :
                            (s_nxt.slot == SL_TQ) ? `SAM_BLK_ONE : `SAM_BLK_SEVEN;
        s_nxt.code        = nAct ? sam_code(s_nxt.slot) : 8'h00;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && s_r.awRdy) begin
            s_nxt.awGot  = 1'b1;
            s_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wRdy) begin
            s_nxt.wGot  = 1'b1;
            s_nxt.wData = s_axi_wdata;
            s_nxt.wStrb = s_axi_wstrb;
        end
        if (s_r.awGot && s_r.wGot && !s_r.bValid) begin
            s_nxt.awGot  = 1'b0;
            s_nxt.wGot   = 1'b0;
            s_nxt.bValid = 1'b1;
            s_nxt.bResp  = mapped(s_r.awAddr) ? `SAM_RESP_OK : `SAM_RESP_ERR;
            unique case (s_r.awAddr)
                `SAM_REG_CTRL: begin
                    if (s_r.wStrb[0]) begin
                        s_nxt.tqSel = s_r.wData[`SAM_CTRL_TQSEL];
                        s_nxt.netEn = s_r.wData[`SAM_CTRL_NETEN];
                    end
                end
                `SAM_REG_THR: begin
                    if (s_r.wStrb[0]) thrNew[7:0]  = s_r.wData[7:0];
                    if (s_r.wStrb[1]) thrNew[15:8] = s_r.wData[15:8];
                    // out-of-range thresholds are dropped, old value kept
                    if (thrNew >= `SAM_THR_MIN && thrNew <= `SAM_THR_MAX) begin
                        s_nxt.thr = thrNew;
                    end
                end
                `SAM_REG_IRQ:  if (s_r.wStrb[0]) irqW1c = s_r.wData[1:0];
                `SAM_REG_MASK: if (s_r.wStrb[0]) s_nxt.irqMask = s_r.wData[1:0];
                default: ;
            endcase
        end
        if (s_r.bValid && s_axi_bready) begin
            s_nxt.bValid = 1'b0;
        end
        s_nxt.awRdy = !s_nxt.awGot && !s_nxt.bValid;
        s_nxt.wRdy  = !s_nxt.wGot && !s_nxt.bValid;

        // read channel: one outstanding read
        if (s_axi_arvalid && s_r.arRdy) begin
            s_nxt.arRdy  = 1'b0;
            s_nxt.rValid = 1'b1;
            s_nxt.rData  = rd_word(s_r, s_axi_araddr);
            s_nxt.rResp  = mapped(s_axi_araddr) ? `SAM_RESP_OK : `SAM_RESP_ERR;
        end else if (s_r.rValid && s_axi_rready) begin
            s_nxt.rValid = 1'b0;
            s_nxt.arRdy  = 1'b1;
        end

        // a new event wins over a same-cycle write-one-to-clear
        s_nxt.irqSt = (s_r.irqSt & ~irqW1c) | irqSet;
        s_nxt.irq   = |(s_nxt.irqSt & s_nxt.irqMask);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= RST_VAL;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fault_free_out = s_r.faultFree;
    assign moveOut        = s_r.moveOut;
    assign readyOut       = s_r.readyOut;
    assign stopOut        = s_r.stopOut;
    assign motorEnOut     = s_r.motorEn;
    assign ledSteady      = s_r.ledSteady;
    assign ledBlinks      = s_r.ledBlk;
    assign alarmCode      = s_r.code;
    assign irq            = s_r.irq;
    assign s_axi_awready  = s_r.awRdy;
    assign s_axi_wready   = s_r.wRdy;
    assign s_axi_bvalid   = s_r.bValid;
    assign s_axi_bresp    = s_r.bResp;
    assign s_axi_arready  = s_r.arRdy;
    assign s_axi_rvalid   = s_r.rValid;
    assign s_axi_rdata    = s_r.rData;
    assign s_axi_rresp    = s_r.rResp;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence idleSeq;
        !act;
    endsequence
    sequence clearSeq;
        clrOk && !anyDet;
    endsequence
    sequence releasedSeq;
        !act && s_r.faultFree && s_r.readyOut && s_r.code == 8'h00;
    endsequence

    hwto_raise_a: assert property (idleSeq and det[SL_TQ] |=> act && s_r.faultFree == 1'b0)
        else $error("torque-off did not raise an alarm");
    home_ofs_a: assert property (idleSeq and (det == (1 << SL_HOMEOFS))
        |=> s_r.code == `SAM_C_HOMEOFS && s_r.motorEn)
        else $error("homing offset alarm wrong");
    mech_limit_a: assert property (idleSeq and (det == (1 << SL_MECH)) |=> s_r.code == `SAM_C_MECH)
        else $error("mechanism limit alarm wrong");
    opdata_raise_a: assert property (idleSeq and sdStart && sdSpeedZero && !det[SL_DEV] |=> act)
        else $error("operation data alarm missing");
    pwr_latch_a: assert property (act && sam_pwr_only(s_r.slot) |=> act ##1 act)
        else $error("power-cycle alarm released");
    powerup_chk_a: assert property ($rose(s_r.started) |-> !($past(wrapRangeBad)) || act)
        else $error("power-up wrap check missed");
    netloss_a: assert property (idleSeq and netLost && operating && s_r.netEn |=> act)
        else $error("network loss alarm missing");
    cpu_code_a: assert property (cpuFault |=> s_r.code == `SAM_C_CPU && s_r.ledSteady && !s_r.motorEn)
        else $error("processor fault not shown");
    dev_raise_a: assert property (idleSeq and posDeviation > s_r.thr |=> act)
        else $error("deviation alarm missing");
    ovl_rest_a: assert property (loadPct <= `SAM_LD_100 |=> s_r.ovl == 14'h0000)
        else $error("overload timer runs at rated load");
    alarm_outs_a: assert property (act |-> !s_r.faultFree && !s_r.moveOut && s_r.stopOut)
        else $error("outputs active during alarm");
    clear_ok_a: assert property (clearSeq |=> releasedSeq)
        else $error("clear did not restore outputs");
    code_hold_a: assert property (act && !clrReq && !anyDet |=> act ##0 $stable(s_r.code))
        else $error("alarm code changed while held");
endmodule : sam_alarm_manager

// ---- tb/sam_host_model.sv ----
// host controller model driving the alarm-clear pin
`timescale 1ns/1ps
module sam_host_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       clearReq,
    input  wire logic [1:0] lag,
    input  wire logic       fault_free_out,
    output logic            fault_clear_in
);
    logic       pend_r;
    logic [1:0] cnt_r;
    // lag models a prompt or a slow host between request and pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pend_r         <= 1'b0;
            cnt_r          <= 2'h0;
            fault_clear_in <= 1'b0;
        end else if (clearReq && !pend_r) begin
            pend_r <= 1'b1;
            cnt_r  <= lag;
        end else if (pend_r && cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end else if (pend_r && !fault_clear_in) begin
            fault_clear_in <= 1'b1;
        end else if (fault_clear_in && fault_free_out) begin
            fault_clear_in <= 1'b0;
            pend_r         <= 1'b0;
        end
    end
endmodule : sam_host_model

// ---- tb/testbench.sv ----
// self-checking bench of the alarm manager
`timescale 1ns/1ps
`include "sam_map.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    import sam_pkg::*;
    logic mclk = 0, rst = 1, torque_off_in_a = 1, torque_off_in_b = 1, wrapEnabled = 1, motionReq = 1;
    logic forward_limit_in = 0, reverse_limit_in = 0, homeOffsetMove = 0, homeSet = 0, atMechLimit = 0;
    logic sdStart = 0, sdSpeedZero = 0, wrapCmd = 0, speedOverLimit = 0, gearRangeBad = 0, wrapRangeBad = 0;
    logic netLost = 0, operating = 0, netModuleErr = 0, cpuFault = 0, clearReq = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [15:0] posDeviation = 0;
    logic [8:0]  loadPct = 9'h064;
    logic [1:0]  lag = 0;
    logic fault_free_out, moveOut, readyOut, stopOut, motorEnOut, ledSteady, irq, fault_clear_in;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, q;
    logic [3:0]  ledBlinks, bl;
    logic [7:0]  alarmCode;
    logic        en;
    logic [7:0]  codes [14] = '{8'h68, 8'h6a, 8'h6a, 8'h6d, 8'h70, 8'h70, 8'h70, 8'h81, 8'h10, 8'h71,
                                8'h72, 8'h82, 8'hf0, 8'h30};
    int n_mismatch = 0, n_compared = 0;

    sam_alarm_manager #(.MS_CYCLES(4)) sam_alarm_manager_inst (.*);
    sam_host_model sam_host_model_inst (.*);

    always #12.5 mclk = ~mclk;

    task automatic close_out();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic do_reset();
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
    endtask : do_reset

    // one register access; waits an edge first so back-to-back calls never clash
    task automatic acc(input bit wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        if (wr) begin
            s_axi_awvalid <= 1;
            s_axi_wvalid  <= 1;
            s_axi_awaddr  <= a;
            s_axi_wdata   <= d;
            s_axi_bready  <= 1;
        end else begin
            s_axi_arvalid <= 1;
            s_axi_araddr  <= a;
            s_axi_rready  <= 1;
        end
        for (int i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (wr && s_axi_bvalid === 1'b1) begin
                rs = s_axi_bresp;
                s_axi_bready <= 0;
                return;
            end
            if (!wr && s_axi_rvalid === 1'b1) begin
                rs = s_axi_rresp;
                q  = s_axi_rdata;
                s_axi_rready <= 0;
                return;
            end
        end
        n_mismatch++;
        close_out();
    endtask : acc

    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        acc(1, a, d);
        `CHK(rs, `SAM_RESP_OK)
    endtask : wreg

    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        acc(0, a, 32'h0);
        `CHK(rs, `SAM_RESP_OK)
        `CHK(q, e)
    endtask : rchk

    task automatic waitAlm(input logic want);
        for (int i = 0; i < 2000; i++) begin
            @(posedge mclk);
            if ((alarmCode !== 8'h00) === want) return;
        end
        n_mismatch++;
        close_out();
    endtask : waitAlm

    task automatic cause(input int k, input logic v);
        case (k)
            0: torque_off_in_a <= !v;
            1: begin
                homeOffsetMove   <= v;
                forward_limit_in <= v;
            end
            2: begin
                homeOffsetMove   <= v;
                reverse_limit_in <= v;
            end
            3: begin
                homeSet     <= v;
                atMechLimit <= v;
            end
            4: begin
                sdStart     <= v;
                sdSpeedZero <= v;
            end
            5: begin
                wrapCmd     <= v;
                wrapEnabled <= !v;
            end
            6: speedOverLimit <= v;
            7: begin
                netLost   <= v;
                operating <= v;
            end
            8: posDeviation <= v ? 16'h0006 : 16'h0000;
            9: gearRangeBad <= v;
            10: wrapRangeBad <= v;
            11: netModuleErr <= v;
            12: cpuFault <= v;
            default: loadPct <= v ? 9'h177 : 9'h064;
        endcase
    endtask : cause

    initial begin
        do_reset();
        rchk(`SAM_REG_CTRL, 32'h2);
        rchk(`SAM_REG_THR, 32'd300);
        rchk(`SAM_REG_MASK, 32'h0);
        rchk(`SAM_REG_STAT, 32'h200);
        acc(0, 5'h14, 32'h0);
        `CHK(rs, `SAM_RESP_ERR)
        acc(1, 5'h14, 32'h0);
        `CHK(rs, `SAM_RESP_ERR)
        wreg(`SAM_REG_THR, 32'd30001);
        rchk(`SAM_REG_THR, 32'd300);
        wreg(`SAM_REG_THR, 32'd30000);
        rchk(`SAM_REG_THR, 32'd30000);
        // both enables off: neither cause may raise an alarm
        wreg(`SAM_REG_CTRL, 32'h0);
        cause(7, 1);
        cause(0, 1);
        repeat (20) @(posedge mclk);
        `CHK(alarmCode, 8'h00)
        cause(7, 0);
        cause(0, 0);
        for (int k = 0; k < 14; k++) begin
            lag <= k[1:0];
            bl = (k == 0) ? 4'h1 : (k == 12) ? 4'h0 : 4'h7;
            en = !(k == 0 || (k >= 9 && k <= 12));
            if (k == 10) begin
                cause(k, 1);
                do_reset();
            end
            wreg(`SAM_REG_CTRL, 32'h3);
            wreg(`SAM_REG_THR, 32'd5);
            wreg(`SAM_REG_MASK, 32'h3);
            cause(k, 1);
            if (k == 13) begin
                repeat (1150) @(posedge mclk);
                `CHK(alarmCode, 8'h00)
            end
            waitAlm(1);
            @(posedge mclk);
            `CHK(alarmCode, codes[k])
            `CHK({fault_free_out, moveOut, stopOut, readyOut}, 4'b0010)
            `CHK(motorEnOut, en)
            `CHK({ledSteady, ledBlinks}, {k == 12, bl})
            `CHK(irq, 1'b1)
            rchk(`SAM_REG_STAT, {16'h0, bl, 1'b0, k == 12, en, 1'b1, codes[k]});
            // host asks for a clear before the cause is gone
            clearReq <= 1'b1;
            @(posedge mclk);
            clearReq <= 1'b0;
            repeat (12) @(posedge mclk);
            `CHK(alarmCode, codes[k])
            cause(k, 0);
            if (k >= 9 && k <= 12) begin
                repeat (20) @(posedge mclk);
                `CHK({alarmCode, motorEnOut}, {codes[k], 1'b0})
                do_reset();
            end else begin
                waitAlm(0);
                @(posedge mclk);
                `CHK({fault_free_out, readyOut, stopOut, moveOut}, 4'b1101)
                rchk(`SAM_REG_IRQ, 32'h3);
                wreg(`SAM_REG_MASK, 32'h0);
                repeat (2) @(posedge mclk);
                `CHK(irq, 1'b0)
                wreg(`SAM_REG_IRQ, 32'h3);
                rchk(`SAM_REG_IRQ, 32'h0);
            end
        end
        close_out();
    end
endmodule : testbench
